// File: adf_core.sv
// alternating push-pull driver sequencer with fault hold-off and soft start
// Behaviour
// - toggle latch steers successive pulses alternately to first and second outputs
// - sync output is high exactly during oscillator discharge phase outside hold-off
// - one sync pulse per oscillator cycle while outputs run
// - on fault sync pulses stop and sync stays low at least 56 cycles
// - during soft start sync leads first driver pulse by two full cycles
// - over-current indication above 0.725 V is a fault starting shutdown
// - over-current turns both outputs off at once, mid-pulse
// - recovery from hold-off to soft-start end spans 64 oscillator cycles
// - first recovery phase keeps drivers and sync off 56 cycles
// - after hold-off two or three sync pulses, then duty ramps up
// - ramp delays the leading edge, 5 to 7 cycles, then full width
// - sync active outside hold-off, also in lead cycles with drivers off; low in lockout and fault
`timescale 1ns/1ps
`default_nettype none
module adf_core
  import adf_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic discharge_node_i,
  input wire logic over_current_i,
  input wire logic undervoltage_lockout_i,
  output logic drive_out_first_o,
  output logic drive_out_second_o,
  output logic sync_o,
  output logic fault_hold_o
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic dis_s;
  logic oc_s;
  logic uv_s;

  adf_sync2 u_sync_dis (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i(discharge_node_i),
    .sync_o(dis_s)
  );
  adf_sync2 u_sync_oc (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i(over_current_i),
    .sync_o(oc_s)
  );
  adf_sync2 u_sync_uv (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i(undervoltage_lockout_i),
    .sync_o(uv_s)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    adf_state_type state;
    logic dis_prev;
    logic [CYC_W-1:0] cyc;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] chg_len;
    logic [POS_W-1:0] blank;
    logic toggle;
    logic out_a;
    logic out_b;
    logic sync;
    logic hold;
  } adf_core_type;

  adf_core_type st_q;
  adf_core_type st_d;

  logic dis_rise;
  logic fault;
  assign dis_rise = dis_s && !st_q.dis_prev;
  assign fault = oc_s || uv_s;

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  // cycles counted at discharge start; charge length measured each cycle
  always_comb
  begin
    st_d = st_q;
    st_d.dis_prev = dis_s;
    if (!dis_s && st_q.pos != POS_MAX)
    begin
      st_d.pos = st_q.pos + POS_ONE;
    end
    if (dis_rise)
    begin
      st_d.chg_len = st_q.pos;
      st_d.pos = POS_ZERO;
    end
    unique case (st_q.state)
      ADF_HOLD:
      begin
        // hold-off count, drivers and sync off
        // leave only on the rise after the last counted one, so that
        // the whole final hold-off cycle stays quiet as well
        if (dis_rise)
        begin
          if (st_q.cyc == HOLDOFF_LAST + CYC_ONE)
          begin
            st_d.state = ADF_LEAD;
            st_d.cyc = CYC_ZERO;
          end
          else
          begin
            st_d.cyc = st_q.cyc + CYC_ONE;
          end
        end
      end
      ADF_LEAD:
      begin
        // sync-only cycles before first drive pulse
        if (dis_rise)
        begin
          if (st_q.cyc == LEAD_LAST)
          begin
            st_d.state = ADF_RAMP;
            st_d.cyc = CYC_ZERO;
            st_d.blank = st_q.pos - (st_q.pos >> 3);
          end
          else
          begin
            st_d.cyc = st_q.cyc + CYC_ONE;
          end
        end
      end
      ADF_RAMP:
      begin
        // leading-edge blank starts at seven eighths of the charge, then two thirds, then shrinks by one sixth per cycle
        if (dis_rise)
        begin
          if (st_q.cyc == RAMP_LAST)
          begin
            st_d.state = ADF_RUN;
            st_d.blank = POS_ZERO;
          end
          else
          begin
            st_d.cyc = st_q.cyc + CYC_ONE;
            st_d.blank = st_q.pos - POS_W'((32'(st_q.pos) * (32'(st_q.cyc) + 32'd2)) / 32'd6);
          end
        end
      end
      ADF_RUN:
      begin
        st_d.cyc = CYC_ZERO;
      end
    endcase
    // toggle latch flips once per discharge in ramp and run
    if (dis_rise && (st_q.state == ADF_RAMP || st_q.state == ADF_RUN))
    begin
      st_d.toggle = !st_q.toggle;
    end
    if (fault)
    begin
      st_d.state = ADF_HOLD;
      st_d.cyc = CYC_ZERO;
      st_d.blank = POS_ZERO;
    end
    st_d.sync = dis_s && !fault && (st_d.state != ADF_HOLD);
    // hold flag registered so the pin comes from a flop
    st_d.hold = (st_d.state == ADF_HOLD);
    // drives low in discharge; lead cycles drive nothing
    st_d.out_a = 1'b0;
    st_d.out_b = 1'b0;
    if (!dis_s && !fault && (st_d.state == ADF_RAMP || st_d.state == ADF_RUN)
        && st_q.pos >= st_d.blank)
    begin
      st_d.out_a = !st_d.toggle;
      st_d.out_b = st_d.toggle;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= '{state: ADF_HOLD, dis_prev: 1'b0, cyc: CYC_ZERO, pos: POS_ZERO,
                chg_len: POS_ZERO, blank: POS_ZERO, toggle: 1'b0, out_a: 1'b0,
                out_b: 1'b0, sync: 1'b0, hold: 1'b1};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign drive_out_first_o = st_q.out_a;
  assign drive_out_second_o = st_q.out_b;
  assign sync_o = st_q.sync;
  assign fault_hold_o = st_q.hold;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_ALTERNATE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !(drive_out_first_o && drive_out_second_o))
    else $error("both drivers high together");
  AST_SYNC_DIS: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (st_q.state != ADF_HOLD && !fault && dis_s) |=> sync_o)
    else $error("sync missing in discharge");
  AST_SYNC_ONE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $rose(sync_o) |-> $past(dis_rise))
    else $error("sync not tied to discharge start");
  AST_HOLD_QUIET: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (st_q.state == ADF_HOLD && st_d.state == ADF_HOLD)
    |=> !sync_o && !drive_out_first_o && !drive_out_second_o)
    else $error("activity in hold-off");
  AST_LEAD_NODRIVE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (st_q.state == ADF_LEAD) |=> !drive_out_first_o && !drive_out_second_o)
    else $error("drive before sync lead");
  AST_OC_OFF: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    oc_s |=> !drive_out_first_o && !drive_out_second_o && !sync_o)
    else $error("drivers on under over-current");
  AST_HOLD_LEN: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (st_q.state == ADF_HOLD && st_d.state == ADF_LEAD) |-> st_q.cyc == HOLDOFF_LAST + CYC_ONE)
    else $error("hold-off too short");
  AST_LEAD_LEN: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (st_q.state == ADF_LEAD && st_d.state == ADF_RAMP) |-> st_q.cyc == LEAD_LAST)
    else $error("sync lead length wrong");
  AST_FAULT_SYNC: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    fault |=> !sync_o)
    else $error("sync high under fault");
  AST_UV_HOLD: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    uv_s |=> fault_hold_o)
    else $error("lockout did not enter hold-off");
  AST_TOGGLE: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (dis_rise && st_q.state == ADF_RUN && !fault) |=> st_q.toggle != $past(st_q.toggle))
    else $error("toggle latch did not flip");
  AST_RAMP_LEN: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (st_q.state == ADF_RAMP && st_d.state == ADF_RUN) |-> st_q.cyc == RAMP_LAST)
    else $error("ramp length wrong");
  AST_DIS_LOW: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $past(dis_s) |-> !drive_out_first_o && !drive_out_second_o)
    else $error("driver high in discharge");
endmodule : adf_core
`default_nettype wire

// File: adf_pkg.sv
// package of constants and types for the alternating driver sequencer
package adf_pkg;
  // ****************************************************************
  // sequencing counts, in oscillator cycles
  // ****************************************************************
  localparam int unsigned HOLDOFF_CYCLES = 56;
  localparam int unsigned TOTAL_RECOVERY_CYCLES = 64;
  localparam int unsigned SYNC_LEAD_CYCLES = 2;
  localparam int unsigned RAMP_CYCLES = TOTAL_RECOVERY_CYCLES - HOLDOFF_CYCLES - SYNC_LEAD_CYCLES;
  localparam int unsigned CYC_W = 7;
  localparam logic [CYC_W-1:0] HOLDOFF_LAST = CYC_W'(HOLDOFF_CYCLES - 1);
  localparam logic [CYC_W-1:0] LEAD_LAST = CYC_W'(SYNC_LEAD_CYCLES - 1);
  localparam logic [CYC_W-1:0] RAMP_LAST = CYC_W'(RAMP_CYCLES - 1);
  localparam logic [CYC_W-1:0] CYC_ZERO = 7'h00;
  localparam logic [CYC_W-1:0] CYC_ONE = 7'h01;
  // ****************************************************************
  // charge-phase position counter used for leading-edge blanking
  // ****************************************************************
  localparam int unsigned POS_W = 16;
  localparam logic [POS_W-1:0] POS_ZERO = 16'h0000;
  localparam logic [POS_W-1:0] POS_ONE = 16'h0001;
  localparam logic [POS_W-1:0] POS_MAX = 16'hffff;
  // over-current trip level, in millivolts, on the analog comparator
  localparam int unsigned OC_TRIP_MV = 725;

  typedef enum logic [1:0] {
    ADF_HOLD,
    ADF_LEAD,
    ADF_RAMP,
    ADF_RUN
  } adf_state_type;
endpackage : adf_pkg

// File: adf_sync2.sv
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module adf_sync2 (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic async_i,
  output logic sync_o
);
  typedef struct packed {
    logic meta;
    logic stable;
  } adf_sync_type;
  adf_sync_type st_q;
  adf_sync_type st_d;

  // first stage feeds only the second
  always_comb
  begin
    st_d.meta = async_i;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.stable;
endmodule : adf_sync2
`default_nettype wire

// File: adf_osc_model.sv
// oscillator model driving the discharge phase indication
`timescale 1ns/1ps
`default_nettype none
module adf_osc_model #(
  parameter int CHARGE = 20,
  parameter int DISCH = 4
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  output logic discharge_o
);
  int cnt;
  // free running ramp; discharge closes each period
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt <= 0;
      discharge_o <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == CHARGE + DISCH - 1) ? 0 : cnt + 1;
      discharge_o <= (cnt >= CHARGE - 1) && (cnt != CHARGE + DISCH - 1);
    end
  end
endmodule : adf_osc_model
`default_nettype wire

// File: adf_core_test.sv
// self-checking bench for the alternating driver sequencer
`timescale 1ns/1ps
`default_nettype none
module adf_core_test;
  import adf_pkg::*;
  localparam int DISCH = 4;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic over_current_i = 1'b0;
  logic undervoltage_lockout_i = 1'b0;
  logic dis, first, second, sync, hold;
  logic dis_prev = 1'b0;
  logic sync_prev = 1'b0;
  int fails = 0;
  int num_checks = 0;
  int dis_edges = 0;
  int sync_edges = 0;
  int width = 0;
  int sync_w = 0;
  int wq[$];
  logic fq[$];
  // 50 ns clock
  initial
  begin
    forever #25 clock_i = ~clock_i;
  end
  adf_osc_model #(.CHARGE(20), .DISCH(DISCH)) osc (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .discharge_o(dis));
  adf_core uut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .discharge_node_i(dis),
    .over_current_i(over_current_i), .undervoltage_lockout_i(undervoltage_lockout_i),
    .drive_out_first_o(first), .drive_out_second_o(second), .sync_o(sync),
    .fault_hold_o(hold));
  // ****************************************************************
  // shared helpers
  // ****************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  end
  endtask : check
  task complete_run;
  begin
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask : complete_run
  // bounded wait: a spent budget ends the run
  task tick(inout int n);
  begin
    @(posedge clock_i);
    #1;
    n--;
    if (n <= 0)
    begin
      fails++;
      complete_run();
    end
  end
  endtask : tick
  // monitor on the falling edge, away from output updates
  always @(negedge clock_i)
  begin
    if (!dis_prev && dis) dis_edges++;
    if (!sync_prev && sync === 1'b1) sync_edges++;
    if (sync === 1'b1)
    begin
      sync_w++;
      check({first, second}, 2'b00);
    end
    else if (sync_prev)
    begin
      check(sync_w, DISCH);
      sync_w = 0;
    end
    if (first === 1'b1 || second === 1'b1)
    begin
      width++;
      if (width == 1) fq.push_back(first);
    end
    else if (width > 0)
    begin
      wq.push_back(width);
      width = 0;
    end
    dis_prev = dis;
    sync_prev = sync;
  end
  task test_startup;
    int n;
  begin
    n = 4000;
    while (sync_edges == 0) tick(n);
    check(dis_edges, 57);
    while (fq.size() == 0) tick(n);
    check(sync_edges >= 2 && sync_edges <= 3, 1'b1);
    while (wq.size() < 10) tick(n);
    for (int i = 1; i < 10; i++) check(fq[i], !fq[i-1]);
    check(wq[0] < wq[6], 1'b1);
    check(wq[6], wq[9]);
    check(sync_edges - 3, wq.size());
    $display("startup test done");
  end
  endtask : test_startup
  // fault or lockout struck in the middle of a full pulse
  task test_shutdown(input logic uv);
    int n;
    int d0;
    int s0;
  begin
    n = 4000;
    wq.delete();
    while (wq.size() < 8) tick(n);
    while (!(first === 1'b1 || second === 1'b1)) tick(n);
    repeat (2) @(posedge clock_i);
    if (uv) undervoltage_lockout_i <= 1'b1;
    else over_current_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    #1;
    check({first, second, sync}, 3'b000);
    check(hold, 1'b1);
    @(posedge clock_i);
    undervoltage_lockout_i <= 1'b0;
    over_current_i <= 1'b0;
    d0 = dis_edges;
    s0 = sync_edges;
    while (sync_edges == s0) tick(n);
    check(dis_edges - d0, 57);
    $display("shutdown test done");
  end
  endtask : test_shutdown
  // main sequence
  initial
  begin
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    test_startup();
    test_shutdown(1'b0);
    test_shutdown(1'b1);
    complete_run();
  end
endmodule : adf_core_test
`default_nettype wire
